//--- core/gdor_regs.v
// direction and output value registers for the pin groups, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "gdor_map.vh"

module gdor_regs
#(
    parameter NUM_GROUPS = 3,
    parameter GRP_W      = 2,
    parameter PIN_W      = 32
)
(
    input  wire                        clk,
    input  wire                        resetn,
    input  wire                        clkEn,
    input  wire                        hsel,
    input  wire [31:0]                 haddr,
    input  wire [1:0]                  htrans,
    input  wire                        hwrite,
    input  wire [2:0]                  hsize,
    input  wire [31:0]                 hwdata,
    input  wire                        hready,
    output wire                        hreadyout,
    output wire                        hresp,
    output wire [31:0]                 hrdata,
    input  wire                        accessProtect,
    input  wire [NUM_GROUPS*PIN_W-1:0] pullResistorEnable,
    output wire [NUM_GROUPS*PIN_W-1:0] pinDirection,
    output wire [NUM_GROUPS*PIN_W-1:0] pinOutputValue,
    output wire [NUM_GROUPS*PIN_W-1:0] padOutEnable,
    output wire [NUM_GROUPS*PIN_W-1:0] padDriveValue,
    output wire [NUM_GROUPS*PIN_W-1:0] padPullActive,
    output wire [NUM_GROUPS*PIN_W-1:0] padPullUp
);

////////////////////////////////////////////////////////////////////////////////
// byte lane mask

function [31:0] laneMask;
    input [2:0] sz;
    input [1:0] a;
    begin
        case (sz)
            `GDOR_HSIZE_BYTE: laneMask = `GDOR_MASK_BYTE << {a, 3'h0};
            `GDOR_HSIZE_HALF: laneMask = `GDOR_MASK_HALF << {a[1], 4'h0};
            `GDOR_HSIZE_WORD: laneMask = `GDOR_MASK_WORD;
            default:          laneMask = `GDOR_MASK_NONE;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// address phase capture

wire                  addrTaken;
reg                   wrPend_q;
reg  [GRP_W-1:0]      wrGrp_q;
reg  [`GDOR_OFF_W-1:0] wrOff_q;
reg  [31:0]           wrMask_q;
reg  [31:0]           hrdata_q;
reg  [31:0]           rdData;
wire [GRP_W-1:0]      aGrp;
wire [`GDOR_OFF_W-1:0] aOff;
wire [NUM_GROUPS*PIN_W-1:0] dirNext;
wire [NUM_GROUPS*PIN_W-1:0] outNext;
wire                  wrApply;
integer               i;

assign addrTaken = clkEn & hsel & htrans[1] & hready;
assign aGrp      = haddr[`GDOR_GRP_LSB+GRP_W-1:`GDOR_GRP_LSB]; // [R8]
assign aOff      = {haddr[`GDOR_OFF_W-1:2], 2'h0};
// writes under protection are dropped [R10]
assign wrApply   = clkEn & wrPend_q & ~accessProtect;

assign hreadyout = clkEn;
assign hresp     = `GDOR_HRESP_OKAY;
assign hrdata    = hrdata_q;

always @(posedge clk)
begin
    if (!resetn)
    begin
        wrPend_q <= 1'b0;
        wrGrp_q  <= {GRP_W{1'b0}};
        wrOff_q  <= {`GDOR_OFF_W{1'b0}};
        wrMask_q <= `GDOR_RESET_VAL;
        hrdata_q <= `GDOR_RESET_VAL;
    end
    else if (clkEn)
    begin
        wrPend_q <= addrTaken & hwrite;
        if (addrTaken)
        begin
            wrGrp_q  <= aGrp;
            wrOff_q  <= aOff;
            wrMask_q <= laneMask(hsize, haddr[1:0]); // [R9]
        end
        if (addrTaken & ~hwrite)
            hrdata_q <= rdData;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read mux, sees any write landing in the same cycle

always @*
begin
    rdData = `GDOR_RESET_VAL;
    for (i = 0; i < NUM_GROUPS; i = i + 1)
    begin
        if (aGrp == i[GRP_W-1:0])
        begin
            case (aOff)
                `GDOR_OFF_DIR,
                `GDOR_OFF_PIN_DIRECTION_CLEAR,
                `GDOR_OFF_PIN_DIRECTION_SET,
                `GDOR_OFF_PIN_DIRECTION_TOGGLE: rdData = dirNext[i*PIN_W +: PIN_W]; // [R5]
                `GDOR_OFF_OUTVAL: rdData = outNext[i*PIN_W +: PIN_W]; // [R6]
                default:          rdData = `GDOR_RESET_VAL;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// one register set per group

genvar g;
generate
    for (g = 0; g < NUM_GROUPS; g = g + 1)
    begin : grp
        localparam [GRP_W-1:0] GIDX = g;
        reg  [PIN_W-1:0] dir_q;
        reg  [PIN_W-1:0] dir_d;
        reg  [PIN_W-1:0] out_q;
        reg  [PIN_W-1:0] out_d;
        wire [PIN_W-1:0] wm;
        wire             hit;

        assign hit = wrApply & (wrGrp_q == GIDX); // [R8]
        assign wm  = hwdata[PIN_W-1:0] & wrMask_q[PIN_W-1:0]; // [R9]

        always @*
        begin
            dir_d = dir_q;
            out_d = out_q;
            if (hit)
            begin
                case (wrOff_q)
                    `GDOR_OFF_DIR:
                        dir_d = (dir_q & ~wrMask_q[PIN_W-1:0]) | wm;
                    `GDOR_OFF_PIN_DIRECTION_CLEAR: dir_d = dir_q & ~wm; // [R2]
                    `GDOR_OFF_PIN_DIRECTION_SET: dir_d = dir_q | wm; // [R3]
                    `GDOR_OFF_PIN_DIRECTION_TOGGLE: dir_d = dir_q ^ wm; // [R4]
                    `GDOR_OFF_OUTVAL:
                        out_d = (out_q & ~wrMask_q[PIN_W-1:0]) | wm; // [R6]
                    default:
                    begin
                        dir_d = dir_q;
                        out_d = out_q;
                    end
                endcase
            end
        end

        always @(posedge clk)
        begin
            if (!resetn)
            begin
                dir_q <= `GDOR_RESET_VAL;
                out_q <= `GDOR_RESET_VAL;
            end
            else if (clkEn)
            begin
                dir_q <= dir_d;
                out_q <= out_d;
            end
        end

        assign dirNext[g*PIN_W +: PIN_W]        = dir_d;
        assign outNext[g*PIN_W +: PIN_W]        = out_d;
        assign pinDirection[g*PIN_W +: PIN_W]   = dir_q;
        assign pinOutputValue[g*PIN_W +: PIN_W] = out_q;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// pad control, registered from the next register values

// pads move on the same edge as the registers, so no extra latency
reg  [NUM_GROUPS*PIN_W-1:0] padOe_q;
reg  [NUM_GROUPS*PIN_W-1:0] padDrv_q;
reg  [NUM_GROUPS*PIN_W-1:0] padPa_q;
reg  [NUM_GROUPS*PIN_W-1:0] padPu_q;
wire [NUM_GROUPS*PIN_W-1:0] padOe_d;
wire [NUM_GROUPS*PIN_W-1:0] padDrv_d;
wire [NUM_GROUPS*PIN_W-1:0] padPa_d;
wire [NUM_GROUPS*PIN_W-1:0] padPu_d;

// 1 drives the pin, 0 leaves it an input [R1]
assign padOe_d  = dirNext;
// driver level for outputs [R7]
assign padDrv_d = outNext & dirNext;
// enabling the driver disables pull; value picks up or down [R7]
assign padPa_d  = pullResistorEnable & ~dirNext;
assign padPu_d  = padPa_d & outNext; // [R7]

always @(posedge clk)
begin
    if (!resetn)
    begin
        padOe_q  <= {(NUM_GROUPS*PIN_W){1'b0}};
        padDrv_q <= {(NUM_GROUPS*PIN_W){1'b0}};
        padPa_q  <= {(NUM_GROUPS*PIN_W){1'b0}};
        padPu_q  <= {(NUM_GROUPS*PIN_W){1'b0}};
    end
    else if (clkEn)
    begin
        padOe_q  <= padOe_d;
        padDrv_q <= padDrv_d;
        padPa_q  <= padPa_d;
        padPu_q  <= padPu_d;
    end
end

assign padOutEnable  = padOe_q;
assign padDriveValue = padDrv_q;
assign padPullActive = padPa_q;
assign padPullUp     = padPu_q;

endmodule

`default_nettype wire

//--- core/gdor_map.vh
// register map, field constants and summary of behaviour for the pin regs
// What this block does
// R1 - direction bit 0 makes its pin an input, 1 makes it an output
// R2 - writing ones to direction-clear clears those direction bits
// R3 - writing ones to direction-set sets those direction bits
// R4 - writing ones to direction-toggle inverts those direction bits
// R5 - direction and its three helpers all read the current direction
// R6 - 32-bit output value register, read/write, resets to zero
// R7 - output pins drive the value; pulled inputs use it as pull direction
// R8 - each group has its own register copy at a 0x80 stride
// R9 - 8-, 16- and 32-bit accesses reach bytes and halves of a register
// R10 - writes are blocked while access protection is on for the block
`ifndef GDOR_MAP_VH
`define GDOR_MAP_VH

`define GDOR_OFF_DIR      7'h00
`define GDOR_OFF_PIN_DIRECTION_CLEAR   7'h04
`define GDOR_OFF_PIN_DIRECTION_SET   7'h08
`define GDOR_OFF_PIN_DIRECTION_TOGGLE   7'h0C
`define GDOR_OFF_OUTVAL   7'h10
`define GDOR_OFF_W        7
`define GDOR_GRP_LSB      7
`define GDOR_RESET_VAL    32'h00000000
`define GDOR_HSIZE_BYTE   3'h0
`define GDOR_HSIZE_HALF   3'h1
`define GDOR_HSIZE_WORD   3'h2
`define GDOR_MASK_BYTE    32'h000000FF
`define GDOR_MASK_HALF    32'h0000FFFF
`define GDOR_MASK_WORD    32'hFFFFFFFF
`define GDOR_MASK_NONE    32'h00000000
`define GDOR_HRESP_OKAY   1'h0

`endif

//--- sim/gdor_regs_props.sv
// assertions on the pin register block ports
`timescale 1ns/1ps
`default_nettype none
module gdor_regs_props
#(
    parameter NUM_GROUPS = 3,
    parameter PIN_W      = 32,
    localparam W         = NUM_GROUPS * PIN_W
)
(
    input wire logic         clk,
    input wire logic         resetn,
    input wire logic         clkEn,
    input wire logic         hsel,
    input wire logic [2:0]   hsize,
    input wire logic [31:0]  haddr,
    input wire logic [1:0]   htrans,
    input wire logic         hwrite,
    input wire logic [31:0]  hwdata,
    input wire logic         hready,
    input wire logic         accessProtect,
    input wire logic [W-1:0] pullResistorEnable,
    input wire logic [W-1:0] pinDirection,
    input wire logic [W-1:0] pinOutputValue,
    input wire logic [W-1:0] padOutEnable,
    input wire logic [W-1:0] padDriveValue,
    input wire logic [W-1:0] padPullActive,
    input wire logic [W-1:0] padPullUp
);
    logic       aW_q;
    logic [8:0] aOff_q;
    wire        wrD = aW_q && clkEn && !accessProtect;
    wire [31:0] d0 = pinDirection[31:0];
    always @(posedge clk)
    begin
        if (!resetn)
            aW_q <= 1'b0;
        else if (clkEn)
            aW_q <= hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
        if (clkEn)
            aOff_q <= haddr[8:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_oe_dir: assert property (padOutEnable == pinDirection)
        else $error("oe differs");
    chk_drive_val: assert property (
        padDriveValue == (pinOutputValue & pinDirection)) else $error("drv");
    chk_pull_up: assert property (clkEn |=> padPullUp ==
        ($past(pullResistorEnable) & ~pinDirection & pinOutputValue))
        else $error("pull");
    chk_pull_act: assert property (clkEn |=> padPullActive ==
        ($past(pullResistorEnable) & ~pinDirection)) else $error("pa");
    chk_dir_write: assert property (wrD && aOff_q == 9'h000 |=>
        d0 == $past(hwdata)) else $error("dir");
    chk_out_write: assert property (wrD && aOff_q == 9'h010 |=>
        pinOutputValue[31:0] == $past(hwdata)) else $error("out");
    chk_protect_hold: assert property (accessProtect |=>
        $stable(pinDirection) && $stable(pinOutputValue)) else $error("prot");
    chk_set_bits: assert property (wrD && aOff_q == 9'h008 |=>
        d0 == ($past(d0) | $past(hwdata))) else $error("set");
    chk_clr_bits: assert property (wrD && aOff_q == 9'h004 |=>
        d0 == ($past(d0) & ~$past(hwdata))) else $error("clr");
    chk_tgl_bits: assert property (wrD && aOff_q == 9'h00C |=>
        d0 == ($past(d0) ^ $past(hwdata))) else $error("tgl");
    chk_reset_zero: assert property (disable iff (1'b0) !resetn |=>
        pinDirection == '0 && pinOutputValue == '0) else $error("rst");
    cov_set: cover property (wrD && aOff_q == 9'h008);
    cov_tgl: cover property (wrD && aOff_q == 9'h00C);
    cov_prot: cover property (aW_q && clkEn && accessProtect);
endmodule
bind gdor_regs gdor_regs_props #(.NUM_GROUPS(NUM_GROUPS), .PIN_W(PIN_W))
    u_props (.*);
`default_nettype wire

//--- sim/gdor_regs_tb_top.sv
// self-checking bench for the pin direction and output registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module gdor_regs_tb_top;
    logic        clk = 0, resetn = 0, clkEn = 1, hwrite = 0, w, p;
    logic [31:0] haddr = 0, hwdata = 0, rd, ex, d, dir [3], out [3];
    logic [1:0]  htrans = 0;
    logic        accessProtect = 0;
    logic [95:0] pull_resistor_enable = 0, md, mo;
    wire         hready;
    wire  [31:0] hrdata;
    wire  [95:0] pinDir, pinOut, padDrv, padPu, padOe, padPa;
    wire         hresp;
    int          seed = 80079, errors = 0, num_checks = 0, g, o;
    always #4 clk = ~clk;
    always @(posedge clk) clkEn <= ($random(seed) % 4) != 0;
    gdor_regs u_gdor_regs (.clk(clk), .resetn(resetn), .clkEn(clkEn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(hresp), .hrdata(hrdata), .accessProtect(accessProtect),
        .pullResistorEnable(pull_resistor_enable), .pinDirection(pinDir),
        .pinOutputValue(pinOut), .padOutEnable(padOe),
        .padDriveValue(padDrv), .padPullActive(padPa), .padPullUp(padPu));
    function automatic logic [31:0] nx(input logic [31:0] v, x, int k);
        case (k)
            1: return v & ~x;
            2: return v | x;
            3: return v ^ x;
            default: return x;
        endcase
    endfunction
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic bus(input logic [31:0] a, dat);
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        accessProtect <= p;
        @(posedge clk);
        while (!hready) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= dat;
        @(posedge clk);
        while (!hready) @(posedge clk);
        rd = hrdata;
        @(posedge clk);
    endtask
    initial
    begin
        for (int k = 0; k < 3; k++) {dir[k], out[k]} = 64'h0;
        repeat (6) @(posedge clk);
        resetn <= 1;
        @(posedge clk);
        for (int i = 0; i < 300; i++)
        begin
            g = (i < 24) ? i / 6 : $unsigned($random(seed)) % 4;
            o = (i < 24) ? i % 6 : $unsigned($random(seed)) % 6;
            w = (i >= 24) && ($random(seed) % 2 != 0);
            p = (i >= 24) && ($random(seed) % 5 == 0);
            d = (i % 7 == 0) ? 32'hFFFFFFFF : $random(seed);
            pull_resistor_enable <= {$random(seed), $random(seed), $random(seed)};
            ex = (g > 2 || o > 4) ? 0 : (i < 24) ? 0 : (o == 4) ? out[g]
                : dir[g];
            bus(g * 128 + o * 4, d);
            if (!w) `CHK(rd, ex)
            if (w && !p && g < 3 && o < 5)
            begin
                if (o < 4) dir[g] = nx(dir[g], d, o);
                if (o == 4) out[g] = d;
            end
            md = {dir[2], dir[1], dir[0]};
            mo = {out[2], out[1], out[0]};
            `CHK(pinDir, md)
            `CHK(pinOut, mo)
            `CHK(padDrv, mo & md)
            `CHK(padPu, pull_resistor_enable & ~md & mo)
            `CHK(padOe, md)
            `CHK(padPa, pull_resistor_enable & ~md)
            `CHK(hresp, 1'b0)
            if (i == 150)
            begin
                resetn <= 0;
                repeat (2) @(posedge clk);
                resetn <= 1;
                @(posedge clk);
                for (int k = 0; k < 3; k++) {dir[k], out[k]} = 64'h0;
                `CHK(pinDir, 96'h0)
            end
        end
        complete_run;
    end
    initial
    begin
        #100000;
        errors++;
        complete_run;
    end
endmodule
`default_nettype wire
